// ==== include/ufw_map.svh ====
/*
 * Constants of the UART flow and wake control link: register offsets,
 * field positions, reset values and timing counts.
 * Assumes inclusion by both ends and the testbench; definitions only.
 */
`ifndef UFW_MAP_SVH
`define UFW_MAP_SVH

// Clock rate and the re-enable delay
`define UFW_CLK_HZ 25000000
`define UFW_WAKE_MS 20
`define UFW_WAKE_CYC ((`UFW_CLK_HZ / 1000) * `UFW_WAKE_MS)

// Idle and periodic listen timing, in cycles
`define UFW_IDLE_CYC 2000
`define UFW_POLL_CYC 1000
`define UFW_LISTEN_CYC 50

// Host register offsets on the AHB-Lite slave
`define UFW_REG_CTRL 8'h00
`define UFW_REG_STAT 8'h04
`define UFW_REG_TXD 8'h08
`define UFW_REG_RXD 8'h0C

// Control register fields
`define UFW_CTRL_FLOW_BIT 0
`define UFW_CTRL_MODE_LSB 1
`define UFW_CTRL_PWR_BIT 3
`define UFW_CTRL_RESET 32'h0000_0001

// Status register fields
`define UFW_STAT_CTS_BIT 0
`define UFW_STAT_TXF_BIT 1
`define UFW_STAT_RXV_BIT 2
`define UFW_STAT_WAKE_BIT 3

`endif

// ==== include/ufw_pkg.sv ====
/*
 * Types shared by both ends of the UART flow and wake control link.
 * Assumes ufw_map.svh for numeric constants.
 */
package ufw_pkg;
    // Power-saving mode setting
    typedef enum logic [1:0] {
        UFW_PSV_OFF,
        UFW_PSV_PERIODIC,
        UFW_PSV_RTS,
        UFW_PSV_RSVD
    } ufw_psv_t;

    // Device power state
    typedef enum logic [1:0] {
        UFW_ACTIVE,
        UFW_IDLE,
        UFW_WAKING
    } ufw_pwr_t;
endpackage

// ==== include/ufw_if.sv ====
/*
 * The link between the module end (device) and the application end (host).
 * Active-low control lines, one data word per transfer; no clocking block.
 */
interface ufw_if;
    logic dtr_n;      // Ready line, host to device, low asserted
    logic rts_n;      // Request line, host to device, low asserted
    logic cts_n;      // Clear-to-send, device to host, low asserted
    logic [7:0] txd;  // Character from host
    logic txd_valid;  // Character strobe from host
    logic [7:0] rxd;  // Character from device
    logic rxd_valid;  // Character strobe from device
    logic supply_on;  // Interface supply of device is up

    modport device (input dtr_n, rts_n, txd, txd_valid,
                    output cts_n, rxd, rxd_valid, supply_on);
    modport host (output dtr_n, rts_n, txd, txd_valid,
                  input cts_n, rxd, rxd_valid, supply_on);
endinterface

// ==== rtl/ufw_device.sv ====
/*
 * Module end of the UART flow and wake control link.
 * Assumes one clock hclk at 25 MHz, asynchronous active-low hresetn,
 * and link inputs synchronous to hclk.
 */
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`include "ufw_map.svh"
module ufw_device
    import ufw_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    ufw_if.device link,
    input wire logic flow_control_on_setting,
    input wire ufw_psv_t power_saving_mode_setting,
    input wire logic activity,
    output logic [7:0] rx_char,
    output logic rx_char_valid,
    input wire logic rx_char_ready,
    input wire logic [7:0] tx_char,
    input wire logic tx_char_valid,
    output logic tx_char_ready,
    output logic uart_enabled,
    output ufw_pwr_t pwr_state
);
    localparam int unsigned WAKE_CYC = `UFW_WAKE_CYC;

    // All state of the device end
    typedef struct packed {
        ufw_pwr_t pwr;
        logic [19:0] cnt;      // Idle, poll or wake counter
        logic listen;          // Periodic receive window open
        logic cts_n;
        logic [7:0] b0, b1;    // Two-entry receive buffer
        logic [1:0] fill;
        logic [7:0] rxd;
        logic rxd_valid;
        logic supply_on;
        logic flow_en;
        logic rxv;             // Buffer holds a word, registered copy
        logic uen;             // Receiver enabled, registered copy
        logic txr;             // Ready toward the local sender
    } ufw_dev_t;

    ufw_dev_t s_r, s_nxt;

    // Ready-line gate: the module receives and clears to send only with the ready line low
    wire dtr_ok = !link.dtr_n;
    wire rx_open = s_r.pwr == UFW_ACTIVE || s_r.listen;
    wire take = link.txd_valid && rx_open && dtr_ok && s_r.fill != 2'd2;
    wire pop = s_r.fill != 2'd0 && rx_char_ready;

    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.supply_on = 1'b1;
        s_nxt.flow_en = flow_control_on_setting;
        s_nxt.rxd_valid = 1'b0;
        // Buffer: pop first, then push; a stall keeps both words
        if (pop) begin
            s_nxt.b0 = s_r.b1;
            s_nxt.fill = s_r.fill - 2'd1;
        end
        if (take && s_r.pwr == UFW_ACTIVE) begin
            if (s_nxt.fill == 2'd0) begin
                s_nxt.b0 = link.txd;
            end else begin
                s_nxt.b1 = link.txd;
            end
            s_nxt.fill = s_nxt.fill + 2'd1;
        end
        // Transmit toward host is a plain strobe
        if (tx_char_valid) begin
            s_nxt.rxd = tx_char;
            s_nxt.rxd_valid = 1'b1;
        end
        case (s_r.pwr)
            UFW_ACTIVE: begin
                // Idle after a quiet spell when power saving is on
                if (activity || link.txd_valid || power_saving_mode_setting == UFW_PSV_OFF) begin
                    s_nxt.cnt = '0;
                end else if (s_r.cnt == 20'(`UFW_IDLE_CYC)) begin
                    s_nxt.pwr = UFW_IDLE;
                    s_nxt.cnt = '0;
                end else begin
                    s_nxt.cnt = s_r.cnt + 20'd1;
                end
            end
            UFW_IDLE: begin
                s_nxt.cnt = s_r.cnt + 20'd1;
                if (activity) begin
                    s_nxt.pwr = UFW_ACTIVE;
                    s_nxt.cnt = '0;
                    s_nxt.listen = 1'b0;
                end else if (power_saving_mode_setting == UFW_PSV_RTS) begin
                    // Request line wakes; receiver stays shut
                    if (!link.rts_n) begin
                        s_nxt.pwr = UFW_WAKING;
                        s_nxt.cnt = '0;
                    end
                end else begin
                    // Periodic listen window
                    if (s_r.cnt == 20'(`UFW_POLL_CYC)) begin
                        s_nxt.listen = 1'b1;
                    end
                    if (s_r.cnt == 20'(`UFW_POLL_CYC + `UFW_LISTEN_CYC)) begin
                        s_nxt.listen = 1'b0;
                        s_nxt.cnt = '0;
                    end
                    // A character here only wakes; it is dropped
                    if (take) begin
                        s_nxt.pwr = UFW_WAKING;
                        s_nxt.cnt = '0;
                        s_nxt.listen = 1'b0;
                    end
                end
            end
            UFW_WAKING: begin
                // Characters before the delay ends are not recognised
                if (s_r.cnt == 20'(WAKE_CYC - 1)) begin
                    s_nxt.pwr = UFW_ACTIVE;
                    s_nxt.cnt = '0;
                end else begin
                    s_nxt.cnt = s_r.cnt + 20'd1;
                end
            end
            default: begin
                s_nxt.pwr = UFW_ACTIVE;
            end
        endcase
        // Clear to send only when active, enabled, flowing and not full; the
        // sender leaves a cycle between words, so dropping it at full is in time
        s_nxt.cts_n = !(s_nxt.pwr == UFW_ACTIVE && s_nxt.flow_en && dtr_ok
            && s_nxt.fill != 2'd2);
        // Outputs toward the local user come straight from flip-flops
        s_nxt.rxv = s_nxt.fill != 2'd0;
        s_nxt.uen = s_nxt.pwr == UFW_ACTIVE;
        s_nxt.txr = 1'b1;
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.pwr <= UFW_ACTIVE;
            s_r.cts_n <= 1'b1;
            s_r.flow_en <= 1'b1;
            s_r.uen <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.cts_n = s_r.cts_n;
    assign link.rxd = s_r.rxd;
    assign link.rxd_valid = s_r.rxd_valid;
    assign link.supply_on = s_r.supply_on;
    assign rx_char = s_r.b0;
    assign rx_char_valid = s_r.rxv;
    assign tx_char_ready = s_r.txr;
    assign uart_enabled = s_r.uen;
    assign pwr_state = s_r.pwr;
endmodule

// ==== rtl/ufw_host.sv ====
/*
 * Application end of the UART flow and wake control link, an AHB-Lite
 * slave. Assumes hclk at 25 MHz and asynchronous active-low hresetn.
 */
`include "ufw_map.svh"
module ufw_host
    import ufw_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    ufw_if.host link,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);
    // All state of the host end
    typedef struct packed {
        logic wr_pend;
        logic [7:0] addr;
        logic flow;            // Host honours CTS
        logic rts_wake;        // Request-line wake in use
        logic [7:0] tx;
        logic tx_full;
        logic [7:0] rx;
        logic rx_val;
        logic wake;            // Send a wake character first
        logic [31:0] rdata;
        logic [7:0] txd;
        logic txd_valid;
        logic rts_n;
        logic rdy;             // Ready toward the bus
        logic err;             // Error response, never raised
    } ufw_host_t;

    ufw_host_t s_r, s_nxt;

    wire addr_ok = hsel && htrans[1] && hready;
    wire up = link.supply_on;

    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.txd_valid = 1'b0;
        s_nxt.rdy = 1'b1;      // No wait states
        s_nxt.err = 1'b0;      // Always OKAY
        s_nxt.wr_pend = addr_ok && hwrite;
        s_nxt.addr = addr_ok ? haddr : s_r.addr;
        // Read data, prepared in the address phase
        if (addr_ok && !hwrite) begin
            case (haddr)
                `UFW_REG_CTRL: s_nxt.rdata = {28'h0, s_r.wake, 1'b0, s_r.rts_wake, s_r.flow};
                `UFW_REG_STAT: s_nxt.rdata = {28'h0, up, s_r.rx_val, s_r.tx_full, link.cts_n};
                `UFW_REG_RXD: s_nxt.rdata = {24'h0, s_r.rx};
                default: s_nxt.rdata = 32'h0000_0000;
            endcase
            if (haddr == `UFW_REG_RXD) begin
                s_nxt.rx_val = 1'b0;
            end
        end
        // Send before the write, so a word written this cycle is not wiped by
        // the clear; a cycle between words lets clear-to-send drop in time
        if (s_r.tx_full && up && !s_r.txd_valid && !(s_r.flow && link.cts_n)) begin
            if (s_r.wake) begin
                s_nxt.txd = 8'h41; // Wake character, buffered by the module when it is active
                s_nxt.wake = 1'b0;
            end else begin
                s_nxt.txd = s_r.tx;
                s_nxt.tx_full = 1'b0;
            end
            s_nxt.txd_valid = 1'b1;
        end
        // Writes in the data phase
        if (s_r.wr_pend) begin
            case (s_r.addr)
                `UFW_REG_CTRL: begin
                    s_nxt.flow = hwdata[`UFW_CTRL_FLOW_BIT];
                    s_nxt.rts_wake = hwdata[`UFW_CTRL_MODE_LSB];
                    s_nxt.wake = hwdata[`UFW_CTRL_PWR_BIT];
                end
                `UFW_REG_TXD: begin
                    s_nxt.tx = hwdata[7:0];
                    s_nxt.tx_full = 1'b1;
                end
                default: ;
            endcase
        end
        // Arriving character; set wins over read clear
        if (link.rxd_valid) begin
            s_nxt.rx = link.rxd;
            s_nxt.rx_val = 1'b1;
        end
        // Request line: asserted only after supply is up
        s_nxt.rts_n = !(up && (s_r.flow || s_r.rts_wake || s_r.tx_full));
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.flow <= 1'b1;
            s_r.rts_n <= 1'b1;
            s_r.rdy <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.dtr_n = 1'b0;
    assign link.rts_n = s_r.rts_n;
    assign link.txd = s_r.txd;
    assign link.txd_valid = s_r.txd_valid;
    assign hrdata = s_r.rdata;
    assign hreadyout = s_r.rdy;
    assign hresp = s_r.err;
endmodule

// ==== bench/ufw_link_checker.sv ====
/* Checker of the wires between the two ends of the link.
   Assumes every wire is synchronous to hclk and hresetn is async low. */
module ufw_link_checker (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic dtr_n,
    input wire logic rts_n,
    input wire logic cts_n,
    input wire logic [7:0] txd,
    input wire logic txd_valid,
    input wire logic [7:0] rxd,
    input wire logic rxd_valid,
    input wire logic supply_on
);
    timeunit 1ns;
    timeprecision 1ns;
    // One domain: one clock and one reset for every check
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Clear-to-send leaves reset high, then drops once the device is active
    sequence s_cts_release;
        cts_n ##1 !cts_n;
    endsequence
    property p_dtr_low;
        dtr_n == 1'b0;
    endproperty
    a_dtr_low: assert property (p_dtr_low)
        else $error("ready line not held low");
    property p_rts_release;
        $rose(hresetn) |-> rts_n;
    endproperty
    a_rts_release: assert property (p_rts_release)
        else $error("request line asserted at reset release");
    property p_cts_release;
        $rose(hresetn) |-> s_cts_release;
    endproperty
    a_cts_release: assert property (p_cts_release)
        else $error("clear-to-send not asserted after reset");
    property p_supply_up;
        $rose(hresetn) |=> supply_on;
    endproperty
    a_supply_up: assert property (p_supply_up)
        else $error("supply not up after reset");
    property p_supply_stays;
        supply_on |=> $stable(supply_on);
    endproperty
    a_supply_stays: assert property (p_supply_stays)
        else $error("supply dropped");
    // Host outputs stay low or idle until the supply is up
    property p_quiet_host;
        !supply_on |-> !txd_valid && rts_n;
    endproperty
    a_quiet_host: assert property (p_quiet_host)
        else $error("host drove link before supply");
    property p_quiet_dev;
        !supply_on |-> cts_n && !rxd_valid;
    endproperty
    a_quiet_dev: assert property (p_quiet_dev)
        else $error("device drove link before supply");
    // A character being sent always shows as an asserted request
    property p_send_with_request;
        txd_valid |-> !rts_n;
    endproperty
    a_send_with_request: assert property (p_send_with_request)
        else $error("character sent without request");
endmodule

// ==== bench/uart_flow_wake_control_tb.sv ====
/* Testbench: both ends joined over the link; AHB-Lite drives the host end,
   the bench drives the device user side. Assumes ufw_map.svh constants. */
`include "ufw_map.svh"
module uart_flow_wake_control_tb
    import ufw_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] hwdata = 32'h0;
    logic flow_on = 1'b1;
    logic activity = 1'b1;
    logic rx_ready = 1'b0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_ch = 8'h00;
    ufw_psv_t psv = UFW_PSV_OFF;
    logic hready, hreadyout, hresp, rx_valid, tx_ready, uart_en;
    logic [7:0] rx_ch;
    logic [31:0] hrdata, q;
    ufw_pwr_t pwr;
    int fail_count = 0;
    int total_checks = 0;
    int cycles = 0;
    // Single slave: its ready is the bus ready
    assign hready = hreadyout;
    ufw_if link ();
    ufw_device ufw_device_i (.hclk(hclk), .hresetn(hresetn), .link(link),
        .flow_control_on_setting(flow_on), .power_saving_mode_setting(psv),
        .activity(activity), .rx_char(rx_ch), .rx_char_valid(rx_valid),
        .rx_char_ready(rx_ready), .tx_char(tx_ch), .tx_char_valid(tx_valid),
        .tx_char_ready(tx_ready), .uart_enabled(uart_en), .pwr_state(pwr));
    ufw_host ufw_host_i (.hclk(hclk), .hresetn(hresetn), .link(link), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    ufw_link_checker ufw_link_checker_i (.hclk(hclk), .hresetn(hresetn),
        .dtr_n(link.dtr_n), .rts_n(link.rts_n), .cts_n(link.cts_n), .txd(link.txd),
        .txd_valid(link.txd_valid), .rxd(link.rxd), .rxd_valid(link.rxd_valid),
        .supply_on(link.supply_on));
    // Free-running 25 MHz clock
    initial begin
        forever #20 hclk = ~hclk;
    end
    // Compare and count; mismatches print at once
    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task final_report();
        $display("checks=%0d errors=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Watchdog: whole run is well under this many cycles
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 40000) begin
            fail_count++;
            final_report();
        end
    end
    // One AHB-Lite single word; read data lands in q at the data-phase edge
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
    endtask
    // Bounded wait for a power state
    task wait_pwr(input ufw_pwr_t s, input int n);
        for (int i = 0; i < n && pwr !== s; i++) @(posedge hclk);
        @(posedge hclk);
    endtask
    // Bounded wait for a character on the host-to-device wire
    task wait_txd();
        for (int i = 0; i < 200 && link.txd_valid !== 1'b1; i++) @(posedge hclk);
        repeat (2) @(posedge hclk);
    endtask
    // Pop one buffered character, then let the head settle
    task pop();
        rx_ready <= 1'b1;
        @(posedge hclk);
        rx_ready <= 1'b0;
        @(posedge hclk);
    endtask
    initial begin
        logic [7:0] chars [3];
        chars = '{8'h5A, 8'hC3, 8'h96};
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values and an unmapped word that reads zero
        ahb(1'b0, `UFW_REG_CTRL, 32'h0);
        check(q, `UFW_CTRL_RESET);
        ahb(1'b0, `UFW_REG_STAT, 32'h0);
        check(q, 32'h0000_0008);
        ahb(1'b1, 8'h10, 32'hFFFF_FFFF);
        ahb(1'b0, 8'h10, 32'h0);
        check(q, 32'h0);
        // Receiver stalls: two words buffered, the third waits on clear-to-send
        foreach (chars[i]) begin
            ahb(1'b1, `UFW_REG_TXD, {24'h0, chars[i]});
            wait_txd();
        end
        check({31'h0, link.cts_n}, 32'h1);
        check({24'h0, rx_ch}, 32'h5A);
        pop();
        check({24'h0, rx_ch}, 32'hC3);
        pop();
        check({24'h0, rx_ch}, 32'h96);
        pop();
        check({31'h0, rx_valid}, 32'h0);
        // Device to host, read clears the valid flag
        tx_ch <= 8'hA5;
        tx_valid <= 1'b1;
        @(posedge hclk);
        tx_valid <= 1'b0;
        for (int i = 0; i < 200 && link.rxd_valid !== 1'b1; i++) @(posedge hclk);
        repeat (2) @(posedge hclk);
        ahb(1'b0, `UFW_REG_RXD, 32'h0);
        check(q, 32'h0000_00A5);
        ahb(1'b0, `UFW_REG_STAT, 32'h0);
        check({31'h0, q[`UFW_STAT_RXV_BIT]}, 32'h0);
        // Periodic idle under flow control: the host holds its word
        psv <= UFW_PSV_PERIODIC;
        activity <= 1'b0;
        wait_pwr(UFW_IDLE, 4000);
        check({30'h0, pwr}, {30'h0, UFW_IDLE});
        check({31'h0, link.cts_n}, 32'h1);
        ahb(1'b1, `UFW_REG_TXD, 32'h77);
        repeat (3 * `UFW_POLL_CYC) @(posedge hclk);
        check({31'h0, rx_valid}, 32'h0);
        activity <= 1'b1;
        for (int i = 0; i < 3000 && rx_valid !== 1'b1; i++) @(posedge hclk);
        check({24'h0, rx_ch}, 32'h77);
        pop();
        // Wake character goes out first, then the word; both land while active
        ahb(1'b1, `UFW_REG_CTRL, 32'h9);
        ahb(1'b1, `UFW_REG_TXD, 32'h33);
        repeat (10) @(posedge hclk);
        check({24'h0, rx_ch}, 32'h41);
        pop();
        check({24'h0, rx_ch}, 32'h33);
        pop();
        // Request-line wake without flow control; early word is dropped
        ahb(1'b1, `UFW_REG_CTRL, 32'h0);
        flow_on <= 1'b0;
        psv <= UFW_PSV_RTS;
        activity <= 1'b0;
        wait_pwr(UFW_IDLE, 4000);
        ahb(1'b1, `UFW_REG_TXD, 32'h66);
        wait_pwr(UFW_WAKING, 200);
        check({30'h0, pwr}, {30'h0, UFW_WAKING});
        repeat (5 * `UFW_POLL_CYC) @(posedge hclk);
        check({30'h0, pwr}, {30'h0, UFW_WAKING});
        check({31'h0, uart_en}, 32'h0);
        check({31'h0, rx_valid}, 32'h0);
        check({31'h0, hresp}, 32'h0);
        check({31'h0, tx_ready}, 32'h1);
        final_report();
    end
endmodule
